// ---- design/keyed_watchdog_cfg.svh ----
/*
 * Constants of the keyed watchdog: key values, counter limits, register
 * offsets, reset values and time figures.
 * Assumes it is included by its bare name from the watchdog design files.
 */
`ifndef KEYED_WATCHDOG_CFG_SVH
`define KEYED_WATCHDOG_CFG_SVH

// Counter and key figures.
`define WDG_COUNT_W        9
`define WDG_COUNT_MAX      9'h1FF
`define WDG_COUNT_RST      9'h000
`define WDG_KEY_FIRST      4'h5
`define WDG_KEY_SECOND     4'hA

// Register offsets on the plain register port.
`define WDG_OFS_KEY        4'h0
`define WDG_OFS_COUNT      4'h1
`define WDG_OFS_STATE      4'h2
`define WDG_OFS_IRQ_STAT   4'h3
`define WDG_OFS_IRQ_MASK   4'h4

// Field positions of the state and interrupt registers.
`define WDG_STATE_RUN_BIT  0
`define WDG_STATE_PTR_BIT  1
`define WDG_STATE_ARM_BIT  2
`define WDG_EVT_OVF_BIT    0
`define WDG_EVT_REJ_BIT    1
`define WDG_EVT_W          2
`define WDG_EVT_RST        2'h0
`define WDG_MASK_RST       2'h0

// Time figures.
`define WDG_LSCLK_HZ       32768
`define WDG_TICK_HZ        256
`define WDG_PERIOD_MS      2000
`define WDG_EARLY_US       3906
`define WDG_CLEAR_LIMIT_US 1996100
`define WDG_PERIOD_TICKS   ((`WDG_PERIOD_MS * `WDG_TICK_HZ) / 1000)
`define WDG_EARLY_LSCLK    ((`WDG_LSCLK_HZ * `WDG_EARLY_US) / 1000000 + 1)

`endif

// ---- design/keyed_watchdog_pkg.sv ----
/*
 * Types shared by the keyed watchdog modules.
 * Assumes keyed_watchdog_cfg.svh supplies the numeric constants.
 */
`include "keyed_watchdog_cfg.svh"

package keyed_watchdog_pkg;

    typedef logic [3:0]                reg_addr_t;
    typedef logic [15:0]               bus_data_t;
    typedef logic [3:0]                key_t;
    typedef logic [`WDG_COUNT_W-1:0]   wdg_count_t;
    typedef logic [`WDG_EVT_W-1:0]     wdg_evt_t;

    typedef enum logic {
        WDG_STOPPED,
        WDG_RUNNING
    } run_state_t;

endpackage : keyed_watchdog_pkg

// ---- design/tick_sync.sv ----
/*
 * Brings the 256 Hz time base tap into the core clock domain and turns
 * each rising edge into a one-cycle tick.
 * Assumes the tap is a slow square wave from another clock domain.
 */
`timescale 1ns/10ps

module tick_sync (
    // Clock and reset.
    input  logic core_clk,
    input  logic rst,
    // Asynchronous tap and synchronous tick.
    input  logic time_base_tap_256hz,
    output logic tick
);

    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic level_reg;
    logic level_next;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= time_base_tap_256hz;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A change is believed only once two stages agree, which filters a late glitch.
    assign level_next = (sync2_reg == sync3_reg) ? sync3_reg : level_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            level_reg <= 1'b0;
        end else begin
            level_reg <= level_next;
        end
    end

    assign tick = level_next & ~level_reg;

endmodule : tick_sync

// ---- design/key_tracker.sv ----
/*
 * Key pointer and first-key memory of the watchdog control register.
 * Assumes writes arrive as one-cycle strobes in the core clock domain.
 */
`timescale 1ns/10ps
`include "keyed_watchdog_cfg.svh"

module key_tracker (
    // Clock and reset.
    input  logic                      core_clk,
    input  logic                      rst,
    // Key writes and overflow.
    input  logic                      key_wr,
    input  keyed_watchdog_pkg::key_t  key_data,
    input  logic                      overflow,
    // State and decisions.
    output logic                      key_ptr,
    output logic                      key_armed,
    output logic                      key_accept,
    output logic                      key_reject
);

    logic ptr_reg;
    logic armed_reg;
    logic first_ok;

    assign first_ok   = key_wr && !ptr_reg && (key_data == `WDG_KEY_FIRST);
    assign key_accept = key_wr && ptr_reg && armed_reg && (key_data == `WDG_KEY_SECOND);
    assign key_reject = key_wr && !first_ok && !key_accept;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ptr_reg <= 1'b0;
        end else if (overflow) begin
            ptr_reg <= 1'b0; // RULE5
        end else if (key_wr) begin
            ptr_reg <= ~ptr_reg; // RULE5
        end
    end

    // The memory only lives while the pointer is 1, so a write at 1 always consumes it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            armed_reg <= 1'b0;
        end else if (overflow) begin
            armed_reg <= 1'b0;
        end else if (first_ok) begin
            armed_reg <= 1'b1; // RULE4
        end else if (key_wr && ptr_reg) begin
            armed_reg <= 1'b0; // RULE12
        end
    end

    assign key_ptr   = ptr_reg;
    assign key_armed = armed_reg;

endmodule : key_tracker

// ---- design/keyed_watchdog_timer.sv ----
/*
 * Keyed watchdog: 9-bit counter on the 256 Hz time base tap, started and
 * cleared by a two-write key sequence, with a non-maskable overflow request.
 * Assumes a register master that uses one-cycle strobes and never waits,
 * and a time base tap that runs from a separate low-speed clock.
 */
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "keyed_watchdog_cfg.svh"

// Overview of operation
// [RULE1] Nine-bit counter advances once per 256 Hz tick while running.
// [RULE2] Key register is four bits, write only, reads back as zero.
// [RULE3] Reset clears the counter and keeps it stopped until started.
// [RULE4] Writing 5H at pointer 0 then 0AH at pointer 1 starts counting.
// [RULE5] Pointer clears on reset or overflow, flips on every key write.
// [RULE6] While running the same two writes clear the counter, counting goes on.
// [RULE7] Wrapping from 1FFH to 000H raises the watchdog request.
// [RULE8] The watchdog request cannot be masked and has top priority.
// [RULE9] Clear to overflow takes 512 ticks, two seconds nominal.
// [RULE10] First tick after a clear may come early, up to one tick.
// [RULE11] Software must repeat the clear within 1.9961 s.
// [RULE12] 5H written at pointer 1 is not a first key, pointer only flips; here it also sets the reject status bit.
// [RULE13] 0AH clears only at pointer 1 after an accepted 5H.
// [RULE14] Unexpected values change nothing but the pointer; here they also set the reject status bit.
// [RULE15] The watchdog request is one core clock pulse per overflow.
module keyed_watchdog_timer (
    // Clock and reset.
    input  logic                           core_clk,
    input  logic                           rst,
    // Register port.
    input  keyed_watchdog_pkg::reg_addr_t  reg_addr,
    input  keyed_watchdog_pkg::bus_data_t  reg_wdata,
    input  logic                           reg_wr,
    input  logic                           reg_rd,
    output keyed_watchdog_pkg::bus_data_t  reg_rdata,
    // Time base.
    input  logic                           time_base_tap_256hz,
    // Interrupts.
    output logic                           watchdog_irq,
    output logic                           irq
);

    keyed_watchdog_pkg::run_state_t  run_reg;
    keyed_watchdog_pkg::run_state_t  run_next;
    keyed_watchdog_pkg::wdg_count_t  count_reg;
    keyed_watchdog_pkg::wdg_count_t  count_next;
    keyed_watchdog_pkg::wdg_evt_t    evt_reg;
    keyed_watchdog_pkg::wdg_evt_t    evt_set;
    keyed_watchdog_pkg::wdg_evt_t    mask_reg;
    keyed_watchdog_pkg::bus_data_t   rdata_reg;
    keyed_watchdog_pkg::bus_data_t   rdata_next;
    logic                            wdg_irq_reg;
    logic                            tick;
    logic                            running;
    logic                            overflow;
    logic                            key_wr;
    logic                            key_ptr;
    logic                            key_armed;
    logic                            key_accept;
    logic                            key_reject;

    // Register selection used by both the write and the read paths.
    function automatic logic hit(
        input keyed_watchdog_pkg::reg_addr_t addr,
        input keyed_watchdog_pkg::reg_addr_t ofs
    );
        hit = (addr == ofs);
    endfunction : hit

    // Places a narrow field in the low bits of a bus word.
    function automatic keyed_watchdog_pkg::bus_data_t widen_evt(
        input keyed_watchdog_pkg::wdg_evt_t v
    );
        widen_evt = {{(16 - `WDG_EVT_W){1'b0}}, v};
    endfunction : widen_evt

    tick_sync u_tick_sync (
        .core_clk            (core_clk),
        .rst                 (rst),
        .time_base_tap_256hz (time_base_tap_256hz),
        .tick                (tick)
    );

    assign key_wr = reg_wr && hit(reg_addr, `WDG_OFS_KEY); // RULE2

    key_tracker u_key_tracker (
        .core_clk   (core_clk),
        .rst        (rst),
        .key_wr     (key_wr),
        .key_data   (reg_wdata[3:0]),
        .overflow   (overflow),
        .key_ptr    (key_ptr),
        .key_armed  (key_armed),
        .key_accept (key_accept),
        .key_reject (key_reject)
    );

    assign running  = (run_reg == keyed_watchdog_pkg::WDG_RUNNING);
    assign overflow = running && tick && (count_reg == `WDG_COUNT_MAX); // RULE7

    // Once started the watchdog only stops again on reset.
    always_comb begin
        run_next = run_reg;
        unique case (run_reg)
            keyed_watchdog_pkg::WDG_STOPPED: begin
                if (key_accept) begin
                    run_next = keyed_watchdog_pkg::WDG_RUNNING; // RULE4
                end
            end
            keyed_watchdog_pkg::WDG_RUNNING: begin
                run_next = keyed_watchdog_pkg::WDG_RUNNING;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            run_reg <= keyed_watchdog_pkg::WDG_STOPPED; // RULE3
        end else begin
            run_reg <= run_next;
        end
    end

    // The tick divider is not reset by a clear, so the first step after a
    // clear may come up to one tick early; the period is 512 ticks less that.
    always_comb begin
        count_next = count_reg;
        if (key_accept) begin
            count_next = `WDG_COUNT_RST; // RULE6 RULE13
        end else if (running && tick) begin
            count_next = count_reg + 9'h001; // RULE1 RULE9 RULE10
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_reg <= `WDG_COUNT_RST; // RULE3
        end else begin
            count_reg <= count_next;
        end
    end

    // The request bypasses the mask so that no setting can silence it.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdg_irq_reg <= 1'b0;
        end else begin
            wdg_irq_reg <= overflow; // RULE8 RULE15
        end
    end

    assign watchdog_irq = wdg_irq_reg;

    always_comb begin
        evt_set                   = `WDG_EVT_RST;
        evt_set[`WDG_EVT_OVF_BIT] = overflow;
        evt_set[`WDG_EVT_REJ_BIT] = key_reject; // RULE14
    end

    // A new event beats a write-one clear in the same cycle.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            evt_reg <= `WDG_EVT_RST;
        end else if (reg_wr && hit(reg_addr, `WDG_OFS_IRQ_STAT)) begin
            evt_reg <= (evt_reg & ~reg_wdata[`WDG_EVT_W-1:0]) | evt_set;
        end else begin
            evt_reg <= evt_reg | evt_set;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mask_reg <= `WDG_MASK_RST;
        end else if (reg_wr && hit(reg_addr, `WDG_OFS_IRQ_MASK)) begin
            mask_reg <= reg_wdata[`WDG_EVT_W-1:0];
        end
    end

    assign irq = |(evt_reg & mask_reg);

    // Unmapped offsets and the key register read as zero.
    always_comb begin
        rdata_next = 16'h0000;
        if (reg_rd) begin
            if (hit(reg_addr, `WDG_OFS_COUNT)) begin
                rdata_next = {7'h00, count_reg};
            end else if (hit(reg_addr, `WDG_OFS_STATE)) begin
                rdata_next[`WDG_STATE_RUN_BIT] = running;
                rdata_next[`WDG_STATE_PTR_BIT] = key_ptr;
                rdata_next[`WDG_STATE_ARM_BIT] = key_armed;
            end else if (hit(reg_addr, `WDG_OFS_IRQ_STAT)) begin
                rdata_next = widen_evt(evt_reg);
            end else if (hit(reg_addr, `WDG_OFS_IRQ_MASK)) begin
                rdata_next = widen_evt(mask_reg);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= rdata_next; // RULE2
        end
    end

    assign reg_rdata = rdata_reg;

    default clocking cb @(posedge core_clk);
    endclocking

    default disable iff (rst);

    a_wrap_raises_irq: assert property ( // RULE7
        (running && tick && count_reg == 9'h1FF)
            |=> (watchdog_irq && count_reg == 9'h000 && !key_ptr)
    ) else $error("overflow did not raise the watchdog request");

    a_irq_single_pulse: assert property ( // RULE15
        watchdog_irq |=> !watchdog_irq
    ) else $error("watchdog request longer than one cycle");

    a_irq_needs_wrap: assert property ( // RULE8
        watchdog_irq |-> ($past(count_reg) == 9'h1FF && $past(tick) && $past(running))
    ) else $error("watchdog request without an overflow");

    a_count_steps_one: assert property ( // RULE1
        (running && tick && !key_accept)
            |=> (count_reg == $past(count_reg) + 9'h001)
    ) else $error("counter did not step on a tick");

    a_count_holds: assert property ( // RULE1
        (!tick && !key_accept) |=> $stable(count_reg)
    ) else $error("counter moved without a tick");

    a_stopped_at_zero: assert property ( // RULE3
        !running |-> (count_reg == 9'h000)
    ) else $error("counter not zero while stopped");

    a_key_start_clear: assert property ( // RULE4
        (key_wr && reg_wdata[3:0] == 4'h5 && !key_ptr && !overflow)
            ##1 (key_wr && reg_wdata[3:0] == 4'hA && !overflow)
            |=> (running && count_reg == 9'h000 && !key_ptr)
    ) else $error("key sequence did not start or clear the counter");

    a_ptr_flips: assert property ( // RULE5
        (key_wr && !overflow) |=> (key_ptr != $past(key_ptr))
    ) else $error("pointer did not flip on a key write");

    a_ptr_overflow_clear: assert property ( // RULE5
        overflow |=> !key_ptr
    ) else $error("pointer not cleared by overflow");

    a_late_first_key: assert property ( // RULE12
        (key_wr && key_ptr && reg_wdata[3:0] == 4'h5)
            |=> (!key_armed && !key_ptr)
    ) else $error("first key taken at pointer one");

    a_bad_second_key: assert property ( // RULE13
        (key_wr && reg_wdata[3:0] == 4'hA && !(key_ptr && key_armed)
            && running && count_reg != 9'h1FF && count_reg != 9'h000)
            |=> (count_reg != 9'h000)
    ) else $error("second key cleared without a valid first key");

    a_other_value_arm: assert property ( // RULE14
        (key_wr && !key_ptr && reg_wdata[3:0] != 4'h5 && !overflow)
            |=> (!key_armed && $stable(run_reg))
    ) else $error("unexpected value changed the key state");

    a_key_reads_zero: assert property ( // RULE2
        (reg_rd && reg_addr == 4'h0) |=> (reg_rdata == 16'h0000)
    ) else $error("key register returned a value");

    a_level_irq: assert property (
        (evt_reg[0] && mask_reg[0]) |-> irq
    ) else $error("unmasked status bit did not raise the interrupt");

    c_start: cover property (
        !running ##1 running
    );

    c_overflow: cover property (
        overflow ##1 watchdog_irq
    );

    c_clear_while_running: cover property (
        running && key_accept && count_reg != 9'h000
    );

    c_rejected_key: cover property (
        key_reject && key_ptr
    );

endmodule : keyed_watchdog_timer

// ---- verification/keyed_watchdog_timer_tb.sv ----
/*
 * Self-checking testbench of the keyed watchdog timer: reset state, start,
 * clear, refused keys, the reject and overflow interrupts and the 512-tick
 * overflow period.
 * Assumes the design files are compiled first and the key, count, state,
 * status and mask registers sit at the offsets of keyed_watchdog_cfg.svh.
 */
`timescale 1ns/10ps
`include "keyed_watchdog_cfg.svh"

module keyed_watchdog_timer_tb;

    logic                          core_clk;
    logic                          rst;
    keyed_watchdog_pkg::reg_addr_t reg_addr;
    keyed_watchdog_pkg::bus_data_t reg_wdata;
    logic                          reg_wr;
    logic                          reg_rd;
    keyed_watchdog_pkg::bus_data_t reg_rdata;
    logic                          time_base_tap_256hz;
    logic                          watchdog_irq;
    logic                          irq;
    int                            failures;
    int                            comparisons;
    int                            irq_pulses;
    logic                          irq_prev;

    keyed_watchdog_timer i_dut (
        .core_clk            (core_clk),
        .rst                 (rst),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .time_base_tap_256hz (time_base_tap_256hz),
        .watchdog_irq        (watchdog_irq),
        .irq                 (irq)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // A request longer than one cycle would count as two overflows.
    always @(posedge core_clk) begin
        if (watchdog_irq === 1'b1) begin
            irq_pulses++;
            if (irq_prev === 1'b1) begin
                failures++;
                $display("CHECK FAILED watchdog_irq width expected 1 seen 2");
            end
        end
        irq_prev <= watchdog_irq;
    end

    task automatic check(input string name, input keyed_watchdog_pkg::bus_data_t exp,
                         input keyed_watchdog_pkg::bus_data_t got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic reg_write(input keyed_watchdog_pkg::reg_addr_t a,
                             input keyed_watchdog_pkg::bus_data_t d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic expect_reg(input string name, input keyed_watchdog_pkg::reg_addr_t a,
                              input keyed_watchdog_pkg::bus_data_t exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        check(name, exp, reg_rdata);
    endtask : expect_reg

    // Each tap period is twelve core cycles, long enough for the synchroniser.
    task automatic pulse_tap(input int n);
        repeat (n) begin
            time_base_tap_256hz <= 1'b1;
            repeat (6) @(posedge core_clk);
            time_base_tap_256hz <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
    endtask : pulse_tap

    task automatic key(input keyed_watchdog_pkg::bus_data_t d);
        reg_write(`WDG_OFS_KEY, d);
    endtask : key

    task automatic test_reset();
        check("watchdog_irq", 16'h0000, {15'h0000, watchdog_irq});
        check("irq", 16'h0000, {15'h0000, irq});
        expect_reg("status", `WDG_OFS_IRQ_STAT, 16'h0000);
        expect_reg("mask", `WDG_OFS_IRQ_MASK, 16'h0000);
        expect_reg("unmapped", 4'hF, 16'h0000);
        pulse_tap(3);
        expect_reg("count", `WDG_OFS_COUNT, 16'h0000);
        expect_reg("state", `WDG_OFS_STATE, 16'h0000);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_start();
        key(16'h0005);
        expect_reg("state", `WDG_OFS_STATE, 16'h0006);
        key(16'h000A);
        expect_reg("state", `WDG_OFS_STATE, 16'h0001);
        expect_reg("key", `WDG_OFS_KEY, 16'h0000);
        pulse_tap(3);
        expect_reg("count", `WDG_OFS_COUNT, 16'h0003);
        $display("test_start done");
    endtask : test_start

    task automatic test_clear();
        key(16'h0005);
        key(16'h000A);
        expect_reg("count", `WDG_OFS_COUNT, 16'h0000);
        pulse_tap(2);
        expect_reg("count", `WDG_OFS_COUNT, 16'h0002);
        key(16'h0003);
        expect_reg("state", `WDG_OFS_STATE, 16'h0003);
        key(16'h000A);
        expect_reg("count", `WDG_OFS_COUNT, 16'h0002);
        expect_reg("state", `WDG_OFS_STATE, 16'h0001);
        $display("test_clear done");
    endtask : test_clear

    task automatic test_refused();
        key(16'h0005);
        key(16'h0005);
        expect_reg("state", `WDG_OFS_STATE, 16'h0001);
        key(16'h000A);
        expect_reg("count", `WDG_OFS_COUNT, 16'h0002);
        expect_reg("state", `WDG_OFS_STATE, 16'h0003);
        expect_reg("status", `WDG_OFS_IRQ_STAT, 16'h0002);
        check("irq", 16'h0000, {15'h0000, irq});
        reg_write(`WDG_OFS_IRQ_MASK, 16'h0002);
        expect_reg("mask", `WDG_OFS_IRQ_MASK, 16'h0002);
        check("irq", 16'h0001, {15'h0000, irq});
        key(16'h0000);
        reg_write(`WDG_OFS_IRQ_STAT, 16'h0002);
        expect_reg("status", `WDG_OFS_IRQ_STAT, 16'h0000);
        check("irq", 16'h0000, {15'h0000, irq});
        $display("test_refused done");
    endtask : test_refused

    task automatic test_overflow();
        reg_write(`WDG_OFS_IRQ_MASK, 16'h0001);
        key(16'h0005);
        key(16'h000A);
        pulse_tap(511);
        expect_reg("count", `WDG_OFS_COUNT, 16'h01FF);
        check("irq pulses", 16'h0000, 16'(irq_pulses));
        pulse_tap(1);
        check("irq pulses", 16'h0001, 16'(irq_pulses));
        expect_reg("count", `WDG_OFS_COUNT, 16'h0000);
        expect_reg("status", `WDG_OFS_IRQ_STAT, 16'h0001);
        check("irq", 16'h0001, {15'h0000, irq});
        reg_write(`WDG_OFS_IRQ_MASK, 16'h0000);
        reg_write(`WDG_OFS_IRQ_STAT, 16'h0001);
        check("irq", 16'h0000, {15'h0000, irq});
        key(16'h0005);
        pulse_tap(512);
        check("irq pulses", 16'h0002, 16'(irq_pulses));
        expect_reg("state", `WDG_OFS_STATE, 16'h0001);
        expect_reg("status", `WDG_OFS_IRQ_STAT, 16'h0001);
        check("irq", 16'h0000, {15'h0000, irq});
        $display("test_overflow done");
    endtask : test_overflow

    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        failures            = 0;
        comparisons         = 0;
        irq_pulses          = 0;
        irq_prev            = 1'b0;
        rst                 = 1'b1;
        reg_addr            = 4'h0;
        reg_wdata           = 16'h0000;
        reg_wr              = 1'b0;
        reg_rd              = 1'b0;
        time_base_tap_256hz = 1'b0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        test_reset();
        test_start();
        test_clear();
        test_refused();
        test_overflow();
        complete_run();
    end

    // About 13000 cycles of traffic; the limit leaves wide margin.
    initial begin
        #200us;
        failures++;
        $display("CHECK FAILED run time expected finish seen timeout");
        complete_run();
    end

endmodule : keyed_watchdog_timer_tb
